// file: dcmd_ctrl.v
// DDR3 command issuing controller driving the memory pins
`timescale 1ns/1ps
`include "dcmd_defines.vh"
module dcmd_ctrl #(
    parameter NBANK = 8,
    parameter BAW = 3,
    parameter AW = 14,
    parameter DW = 16
) (
    input wire CLOCK,
    input wire SYS_RST,
    // User request side
    input wire REQ_VALID,
    input wire [3:0] REQ_OP,
    input wire [BAW-1:0] REQ_BANK,
    input wire [AW-1:0] REQ_ADDR,
    input wire REQ_OTF,             // Request on-the-fly burst choice
    input wire REQ_BL8,             // One: burst of eight
    input wire REQ_ODT,             // Request termination on
    input wire MODE_OTF_EN,         // Mode register allows burst choice
    input wire MODE_RTT_EN,         // Mode registers enable termination
    input wire [2*DW-1:0] WR_DATA,  // Rise beat low, fall beat high
    input wire [3:0] WR_MASK,       // {upper fall, upper rise, lower fall, lower rise}
    input wire MEM_RESET_REQ,       // Request device reset
    output reg REQ_READY,
    output reg REQ_DONE,
    output reg [1:0] REQ_ERR,
    output reg WR_TAKE,             // Data beat pair of the previous cycle consumed
    output reg [NBANK-1:0] BANK_OPEN,
    output reg [1:0] PWR_STATE,
    // Memory pins
    output reg MEM_RESET_N,
    output reg MEM_CKE,
    output reg MEM_CS_N,
    output reg MEM_RAS_N,
    output reg MEM_CAS_N,
    output reg MEM_WE_N,
    output reg [BAW-1:0] MEM_BA,
    output reg [AW-1:0] MEM_A,
    output reg MEM_ODT,
    output reg [DW/2-1:0] MEM_DQ_LO_RISE,
    output reg [DW/2-1:0] MEM_DQ_LO_FALL,
    output reg [DW/2-1:0] MEM_DQ_HI_RISE,
    output reg [DW/2-1:0] MEM_DQ_HI_FALL,
    output reg [1:0] MEM_LDM,       // Lower mask, rise then fall
    output reg [1:0] MEM_UDM,       // Upper mask, rise then fall
    output reg MEM_DQ_OE,
    output reg MEM_DQS_OE,
    input wire [2*DW-1:0] MEM_DQ_IN,// Captured read beats from pads
    output reg [2*DW-1:0] RD_DATA,
    output reg RD_VALID
);

    // ************************************************************
    // Declarations
    // ************************************************************
    reg [2*DW-1:0] rd_s1;           // First pad sync stage
    reg [2*DW-1:0] rd_s2;           // Second pad sync stage
    reg [2:0] beats;                // Write beat pairs left
    reg rd_pend;                    // Read data expected
    reg [2:0] rd_beats;             // Read beat pairs left
    reg cke_prev;                   // CKE level of the previous cycle
    reg bank_state_ok;              // Selected bank state fits request
    reg pwr_ok;                     // Power state fits request
    reg code_ok;                    // Request code known
    reg next_ok;
    reg next_bl8;
    wire take;
    wire lane_load;
    wire [DW/2-1:0] lo_r;
    wire [DW/2-1:0] lo_f;
    wire [DW/2-1:0] hi_r;
    wire [DW/2-1:0] hi_f;
    wire [1:0] lo_m;
    wire [1:0] hi_m;

    assign take = REQ_VALID & REQ_READY;
    assign lane_load = (beats != 3'h0);

    // ************************************************************
    // Request check against bank and power state
    // ************************************************************
    // Bank state is judged for the addressed bank for ACT, WR and RD, for all banks for MRS, REF, SRE, PDE and ZQ, not at all for the rest
    always @* begin
        bank_state_ok = 1'b1;
        pwr_ok = (PWR_STATE == `DCMD_PS_ON);
        code_ok = 1'b1;
        next_bl8 = 1'b1;
        case (REQ_OP)
            `DCMD_OP_ACT: bank_state_ok = ~BANK_OPEN[REQ_BANK];
            `DCMD_OP_WR, `DCMD_OP_RD: bank_state_ok = BANK_OPEN[REQ_BANK];
            `DCMD_OP_MRS, `DCMD_OP_REF, `DCMD_OP_SRE, `DCMD_OP_PDE,
            `DCMD_OP_ZQL, `DCMD_OP_ZQS: bank_state_ok = ~(|BANK_OPEN);
            `DCMD_OP_LPX: pwr_ok = (PWR_STATE != `DCMD_PS_ON);
            `DCMD_OP_PRE, `DCMD_OP_PREA, `DCMD_OP_NOP, `DCMD_OP_DES: bank_state_ok = 1'b1;
            default: code_ok = 1'b0;
        endcase
        // Burst choice only when the mode register allows it
        if (MODE_OTF_EN && REQ_OTF) begin
            next_bl8 = REQ_BL8;
        end
        next_ok = bank_state_ok & pwr_ok & code_ok;
    end

    // ************************************************************
    // Command issue
    // ************************************************************
    // One request per two cycles; idle cycles present NOP
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            REQ_READY <= 1'b0;
            REQ_DONE <= 1'b0;
            REQ_ERR <= `DCMD_ERR_NONE;
            BANK_OPEN <= {NBANK{1'b0}};
            PWR_STATE <= `DCMD_PS_ON;
            MEM_RESET_N <= 1'b0;
            MEM_CKE <= 1'b0;
            cke_prev <= 1'b0;
            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_DES;
            MEM_BA <= {BAW{1'b0}};
            MEM_A <= {AW{1'b0}};
            MEM_ODT <= 1'b0;
            beats <= 3'h0;
            rd_pend <= 1'b0;
            WR_TAKE <= 1'b0;
        end else begin
            MEM_RESET_N <= ~MEM_RESET_REQ;
            REQ_DONE <= 1'b0;
            WR_TAKE <= lane_load;
            beats <= lane_load ? beats - 3'h1 : 3'h0;
            MEM_ODT <= REQ_ODT & MODE_RTT_EN;
            cke_prev <= MEM_CKE;
            // Default: CKE holds, NOP on the pins whether CKE is up or down
            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_NOP;
            REQ_READY <= ~REQ_READY & ~lane_load & ~MEM_RESET_REQ;
            if (MEM_RESET_REQ) begin
                MEM_CKE <= 1'b0;
                BANK_OPEN <= {NBANK{1'b0}};
                PWR_STATE <= `DCMD_PS_ON;
                {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_DES;
            end else if (~MEM_CKE && PWR_STATE == `DCMD_PS_ON) begin
                MEM_CKE <= 1'b1;                                    // Raise after reset
            end else if (take) begin
                REQ_DONE <= 1'b1;
                MEM_BA <= REQ_BANK;
                MEM_A <= REQ_ADDR;
                if (!next_ok) begin
                    REQ_ERR <= ~code_ok ? `DCMD_ERR_CODE :
                               (~pwr_ok ? `DCMD_ERR_PWR : `DCMD_ERR_BANK);
                end else begin
                    REQ_ERR <= `DCMD_ERR_NONE;
                    case (REQ_OP)
                        `DCMD_OP_ACT: begin
                            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_ACT;
                            BANK_OPEN[REQ_BANK] <= 1'b1;
                        end
                        `DCMD_OP_PRE, `DCMD_OP_PREA: begin
                            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_PRE;
                            MEM_A[`DCMD_A_AP] <= (REQ_OP == `DCMD_OP_PREA);
                            if (REQ_OP == `DCMD_OP_PREA) begin
                                BANK_OPEN <= {NBANK{1'b0}};
                            end else begin
                                BANK_OPEN[REQ_BANK] <= 1'b0;
                            end
                        end
                        `DCMD_OP_WR, `DCMD_OP_RD: begin
                            if (REQ_OP == `DCMD_OP_WR) begin
                                {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_WR;
                                beats <= next_bl8 ? `DCMD_BEATS_BL8 + 3'h1 :
                                         `DCMD_BEATS_BC4 + 3'h1;
                            end else begin
                                {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_RD;
                            end
                            MEM_A[`DCMD_A_BC] <= next_bl8;
                            if (REQ_ADDR[`DCMD_A_AP]) begin
                                BANK_OPEN[REQ_BANK] <= 1'b0;
                            end
                        end
                        `DCMD_OP_MRS: begin
                            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_MRS;
                        end
                        `DCMD_OP_REF: begin
                            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_REF;
                        end
                        `DCMD_OP_SRE: begin
                            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_REF;
                            MEM_CKE <= 1'b0;
                            PWR_STATE <= `DCMD_PS_SR;
                        end
                        `DCMD_OP_PDE: begin
                            MEM_CKE <= 1'b0;
                            PWR_STATE <= `DCMD_PS_PD;
                        end
                        `DCMD_OP_LPX: begin
                            MEM_CKE <= 1'b1;
                            PWR_STATE <= `DCMD_PS_ON;
                        end
                        `DCMD_OP_ZQL, `DCMD_OP_ZQS: begin
                            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_ZQ;
                            MEM_A[`DCMD_A_AP] <= (REQ_OP == `DCMD_OP_ZQL);
                        end
                        `DCMD_OP_DES: begin
                            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_DES;
                        end
                        default: begin
                            {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= `DCMD_PIN_NOP;
                        end
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // Write data lanes and output enables
    // ************************************************************
    dcmd_wrlane #(.W(DW/2)) u_lo (
        .clk(CLOCK),
        .rst(SYS_RST),
        .load(lane_load),
        .data({WR_DATA[DW+DW/2-1:DW], WR_DATA[DW/2-1:0]}),
        .mask(WR_MASK[1:0]),
        .q_rise(lo_r),
        .q_fall(lo_f),
        .dm(lo_m)
    );

    dcmd_wrlane #(.W(DW/2)) u_hi (
        .clk(CLOCK),
        .rst(SYS_RST),
        .load(lane_load),
        .data({WR_DATA[2*DW-1:DW+DW/2], WR_DATA[DW-1:DW/2]}),
        .mask(WR_MASK[3:2]),
        .q_rise(hi_r),
        .q_fall(hi_f),
        .dm(hi_m)
    );

    // Registered pad drive; rise and fall beats go out on both strobe edges
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            MEM_DQ_LO_RISE <= {(DW/2){1'b0}};
            MEM_DQ_LO_FALL <= {(DW/2){1'b0}};
            MEM_DQ_HI_RISE <= {(DW/2){1'b0}};
            MEM_DQ_HI_FALL <= {(DW/2){1'b0}};
            MEM_LDM <= 2'h3;
            MEM_UDM <= 2'h3;
            MEM_DQ_OE <= 1'b0;
            MEM_DQS_OE <= 1'b0;
        end else begin
            MEM_DQ_LO_RISE <= lo_r;
            MEM_DQ_LO_FALL <= lo_f;
            MEM_DQ_HI_RISE <= hi_r;
            MEM_DQ_HI_FALL <= hi_f;
            MEM_LDM <= lo_m;
            MEM_UDM <= hi_m;
            MEM_DQ_OE <= WR_TAKE;
            MEM_DQS_OE <= WR_TAKE;
        end
    end

    // ************************************************************
    // Read capture
    // ************************************************************
    // Pad data passes two flip-flops before use
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            rd_s1 <= {(2*DW){1'b0}};
            rd_s2 <= {(2*DW){1'b0}};
            RD_DATA <= {(2*DW){1'b0}};
            RD_VALID <= 1'b0;
            rd_beats <= 3'h0;
        end else begin
            rd_s1 <= MEM_DQ_IN;
            rd_s2 <= rd_s1;
            RD_DATA <= rd_s2;
            RD_VALID <= (rd_beats != 3'h0);
            if (take && next_ok && REQ_OP == `DCMD_OP_RD) begin
                rd_beats <= next_bl8 ? `DCMD_BEATS_BL8 + 3'h1 : `DCMD_BEATS_BC4 + 3'h1;
            end else if (rd_beats != 3'h0) begin
                rd_beats <= rd_beats - 3'h1;
            end
        end
    end

endmodule

// file: dcmd_defines.vh
// Constants for the DDR3 command issuing controller
`ifndef DCMD_DEFINES_VH
`define DCMD_DEFINES_VH

// ****************************************************************
// User command codes
// ****************************************************************
`define DCMD_OP_NOP 4'h0
`define DCMD_OP_ACT 4'h1
`define DCMD_OP_PRE 4'h2
`define DCMD_OP_PREA 4'h3
`define DCMD_OP_WR 4'h4
`define DCMD_OP_RD 4'h5
`define DCMD_OP_MRS 4'h6
`define DCMD_OP_REF 4'h7
`define DCMD_OP_SRE 4'h8
`define DCMD_OP_PDE 4'h9
`define DCMD_OP_LPX 4'hA
`define DCMD_OP_ZQL 4'hB
`define DCMD_OP_ZQS 4'hC
`define DCMD_OP_DES 4'hD

// ****************************************************************
// Pin codes {CS#, RAS#, CAS#, WE#}
// ****************************************************************
`define DCMD_PIN_ACT 4'h3
`define DCMD_PIN_PRE 4'h2
`define DCMD_PIN_WR 4'h4
`define DCMD_PIN_RD 4'h5
`define DCMD_PIN_MRS 4'h0
`define DCMD_PIN_REF 4'h1
`define DCMD_PIN_NOP 4'h7
`define DCMD_PIN_ZQ 4'h6
`define DCMD_PIN_DES 4'hF

// ****************************************************************
// Address bit positions
// ****************************************************************
`define DCMD_A_AP 10
`define DCMD_A_BC 12

// ****************************************************************
// Controller power states
// ****************************************************************
`define DCMD_PS_ON 2'h0
`define DCMD_PS_PD 2'h1
`define DCMD_PS_SR 2'h2

// Error codes
`define DCMD_ERR_NONE 2'h0
`define DCMD_ERR_BANK 2'h1
`define DCMD_ERR_PWR 2'h2
`define DCMD_ERR_CODE 2'h3

// Burst clocks minus one, for writes and reads: two edges per clock
`define DCMD_BEATS_BL8 3'h3
`define DCMD_BEATS_BC4 3'h1

`endif

// file: dcmd_wrlane.v
// One write byte lane with its mask, double data rate
`timescale 1ns/1ps
module dcmd_wrlane #(
    parameter W = 8
) (
    input wire clk,
    input wire rst,
    input wire load,                // Take a new beat pair
    input wire [2*W-1:0] data,      // Rise beat in low half
    input wire [1:0] mask,          // Per beat mask, high blocks
    output reg [W-1:0] q_rise,
    output reg [W-1:0] q_fall,
    output reg [1:0] dm
);

    // ************************************************************
    // Lane register
    // ************************************************************
    // Holds one beat pair; the mask travels with its own lane only
    always @(posedge clk) begin
        if (rst) begin
            q_rise <= {W{1'b0}};
            q_fall <= {W{1'b0}};
            dm <= 2'h3;
        end else if (load) begin
            q_rise <= data[W-1:0];
            q_fall <= data[2*W-1:W];
            dm <= mask;
        end else begin
            dm <= 2'h3;                 // Block lane outside a burst
        end
    end

endmodule

// file: dcmd_ctrl_monitor.sv
// Assertion checker bound to the DDR3 command controller
`timescale 1ns/1ps
`include "dcmd_defines.vh"
module dcmd_ctrl_monitor #(
    parameter NBANK = 8,
    parameter BAW = 3,
    parameter AW = 14
) (
    input wire CLOCK,
    input wire SYS_RST,
    input wire REQ_VALID,
    input wire REQ_READY,
    input wire [3:0] REQ_OP,
    input wire [BAW-1:0] REQ_BANK,
    input wire REQ_OTF,
    input wire REQ_BL8,
    input wire MODE_OTF_EN,
    input wire MODE_RTT_EN,
    input wire MEM_RESET_REQ,
    input wire REQ_DONE,
    input wire [1:0] REQ_ERR,
    input wire [NBANK-1:0] BANK_OPEN,
    input wire [1:0] PWR_STATE,
    input wire MEM_RESET_N,
    input wire MEM_CS_N,
    input wire MEM_RAS_N,
    input wire MEM_CAS_N,
    input wire MEM_WE_N,
    input wire [BAW-1:0] MEM_BA,
    input wire [AW-1:0] MEM_A,
    input wire MEM_ODT
);
    // ****************************************
    // Helpers and properties
    // ****************************************
    wire take = REQ_VALID && REQ_READY; // Request accepted at this edge
    wire on = PWR_STATE == `DCMD_PS_ON; // Device awake
    wire [3:0] cmd = {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N}; // Pin command
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    property p_done;
        take |=> REQ_DONE;
    endproperty
    a_done: assert property (p_done) else $error("done missing after take");
    property p_act;
        take && REQ_OP == `DCMD_OP_ACT && !BANK_OPEN[REQ_BANK] && on |=> cmd == `DCMD_PIN_ACT && MEM_BA == $past(REQ_BANK);
    endproperty
    a_act: assert property (p_act) else $error("activate pins wrong");
    property p_pre;
        take && (REQ_OP == `DCMD_OP_PRE || REQ_OP == `DCMD_OP_PREA) && on |=> cmd == `DCMD_PIN_PRE && MEM_A[10] == $past(REQ_OP[0]);
    endproperty
    a_pre: assert property (p_pre) else $error("precharge pins wrong");
    property p_wr;
        take && REQ_OP == `DCMD_OP_WR && BANK_OPEN[REQ_BANK] && on |=> cmd == `DCMD_PIN_WR && MEM_A[12] == $past(!(REQ_OTF && MODE_OTF_EN) || REQ_BL8);
    endproperty
    a_wr: assert property (p_wr) else $error("write burst choice wrong");
    property p_stand;
        !MEM_CS_N && cmd != `DCMD_PIN_NOP |=> MEM_CS_N || cmd == `DCMD_PIN_NOP;
    endproperty
    a_stand: assert property (p_stand) else $error("command held too long");
    property p_odt;
        take && !MODE_RTT_EN |=> !MEM_ODT;
    endproperty
    a_odt: assert property (p_odt) else $error("termination while disabled");
    property p_rst;
        MEM_RESET_REQ |=> !MEM_RESET_N;
    endproperty
    a_rst: assert property (p_rst) else $error("device reset not driven");
    property p_bad;
        take && REQ_OP > `DCMD_OP_DES |=> REQ_ERR == `DCMD_ERR_CODE && (MEM_CS_N || cmd == `DCMD_PIN_NOP);
    endproperty
    a_bad: assert property (p_bad) else $error("reserved code not refused");
endmodule
bind dcmd_ctrl dcmd_ctrl_monitor #(.NBANK(NBANK), .BAW(BAW), .AW(AW)) mon (.*);

// file: dcmd_dev_model.sv
// Behavioural DDR3 device seen from its command pins
`timescale 1ns/1ps
module dcmd_dev_model (
    input wire clk,
    input wire reset_n,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [2:0] ba,
    input wire [13:0] a,
    input wire odt,
    input wire rtt_en,
    output reg [31:0] dq,
    output reg [7:0] open,
    output integer bad
);
    reg cke_q; // CKE one clock before the command
    reg rtt_on; // Termination applied to data and strobes
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    initial begin
        dq = 32'h0;
        open = 8'h00;
        bad = 0;
        cke_q = 1'b0;
        rtt_on = 1'b0;
    end
    // ****************************************
    // Pads and command decode
    // ****************************************
    // Read pads change every cycle so stale data never matches
    always @(posedge clk) dq <= dq + 32'h9E3779B9;
    // Per-bank state, counts every illegal command
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open <= 8'h00;
            cke_q <= 1'b0;
            rtt_on <= 1'b0;
        end else begin
            cke_q <= cke;
            rtt_on <= odt && rtt_en;
            if (cs_n || !cke_q) begin
                if (!cke_q && cke && !cs_n && cmd != 4'h7) bad <= bad + 1;
            end else case (cmd)
                4'h3: begin
                    if (open[ba] || !cke) bad <= bad + 1;
                    open[ba] <= 1'b1;
                end
                4'h2: if (a[10]) open <= 8'h00; else open[ba] <= 1'b0;
                4'h4, 4'h5: begin
                    if (!open[ba]) bad <= bad + 1;
                    if (a[10]) open[ba] <= 1'b0;
                end
                4'h0, 4'h1, 4'h6: if (open != 8'h00) bad <= bad + 1;
                4'h7: if (!cke && open != 8'h00) bad <= bad + 1;
                default: bad <= bad + 1;
            endcase
        end
    end
endmodule

// file: dcmd_ctrl_tb.sv
// Self-checking bench for the DDR3 command controller
`timescale 1ns/1ps
`include "dcmd_defines.vh"
module dcmd_ctrl_tb;
    reg CLOCK, SYS_RST, REQ_VALID, REQ_OTF, REQ_BL8, REQ_ODT, MODE_OTF_EN, MODE_RTT_EN;
    reg MEM_RESET_REQ;
    reg [3:0] REQ_OP, WR_MASK, pm;
    reg [2:0] REQ_BANK;
    reg [13:0] REQ_ADDR;
    reg [31:0] WR_DATA, pd, s;
    reg [31:0] pq, r1, r2, r3; // Lane data two samples back, pad data history
    reg [3:0] pmq; // Lane mask two samples back
    wire REQ_READY, REQ_DONE, WR_TAKE, RD_VALID, MEM_RESET_N, MEM_CKE, MEM_CS_N, MEM_RAS_N;
    wire MEM_CAS_N, MEM_WE_N, MEM_ODT, MEM_DQ_OE, MEM_DQS_OE;
    wire [1:0] REQ_ERR, PWR_STATE, MEM_LDM, MEM_UDM;
    wire [7:0] BANK_OPEN, MEM_DQ_LO_RISE, MEM_DQ_LO_FALL, MEM_DQ_HI_RISE, MEM_DQ_HI_FALL, dev_open;
    wire [2:0] MEM_BA;
    wire [13:0] MEM_A;
    wire [31:0] MEM_DQ_IN, RD_DATA, dev_bad;
    wire [3:0] cmd = {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N}; // Pin command
    integer fail_count, comparisons, i, nt, nr, j;
    reg [7:0] open_m; // Model of open banks
    reg cke_m, tk, a12;
    reg [1:0] ee;
    reg [3:0] pin;
    // Sequence of idle commands, left first
    localparam [39:0] SEQ = {`DCMD_OP_MRS, `DCMD_OP_REF, `DCMD_OP_ZQL, `DCMD_OP_ZQS,
        `DCMD_OP_NOP, `DCMD_OP_DES, `DCMD_OP_PDE, `DCMD_OP_LPX, `DCMD_OP_SRE, `DCMD_OP_LPX};
    dcmd_ctrl dut (.*);
    dcmd_dev_model dev (.clk(CLOCK), .reset_n(MEM_RESET_N), .cke(MEM_CKE), .cs_n(MEM_CS_N),
        .ras_n(MEM_RAS_N), .cas_n(MEM_CAS_N), .we_n(MEM_WE_N), .ba(MEM_BA), .a(MEM_A),
        .odt(MEM_ODT), .rtt_en(MODE_RTT_EN), .dq(MEM_DQ_IN), .open(dev_open), .bad(dev_bad));
    // ****************************************
    // Clock, data and checking tasks
    // ****************************************
    initial begin
        CLOCK = 1'b0;
        forever #2 CLOCK = ~CLOCK;
    end
    // Fresh write beats and masks every cycle
    always @(posedge CLOCK) begin
        WR_DATA <= $urandom;
        WR_MASK <= $urandom;
    end
    // Pad data history; read data appears three samples after the pads
    always @(negedge CLOCK) begin
        r1 <= MEM_DQ_IN;
        r2 <= r1;
        r3 <= r2;
    end
    task chk(input ok, input string what);
        begin
            comparisons = comparisons + 1;
            if (!ok) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t %0s", $time, what);
            end
        end
    endtask
    task give_verdict;
        begin
            if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    // One request, checked against the bench model
    task issue(input [3:0] op, input [2:0] b, input [13:0] ad);
        begin
            @(posedge CLOCK);
            s = $urandom;
            REQ_VALID <= 1'b1;
            REQ_OP <= op;
            REQ_BANK <= b;
            REQ_ADDR <= ad;
            {MODE_RTT_EN, REQ_ODT, MODE_OTF_EN, REQ_BL8, REQ_OTF} <= s[4:0];
            a12 = !(s[0] && s[2]) || s[1];
            ee = `DCMD_ERR_NONE;
            if (op > `DCMD_OP_DES) ee = `DCMD_ERR_CODE;
            else if (op == `DCMD_OP_ACT && open_m[b] || (op == `DCMD_OP_WR || op == `DCMD_OP_RD) && !open_m[b]) ee = `DCMD_ERR_BANK;
            case (op)
                `DCMD_OP_ACT: pin = `DCMD_PIN_ACT;
                `DCMD_OP_PRE, `DCMD_OP_PREA: pin = `DCMD_PIN_PRE;
                `DCMD_OP_WR: pin = `DCMD_PIN_WR;
                `DCMD_OP_RD: pin = `DCMD_PIN_RD;
                `DCMD_OP_MRS: pin = `DCMD_PIN_MRS;
                `DCMD_OP_REF, `DCMD_OP_SRE: pin = `DCMD_PIN_REF;
                `DCMD_OP_ZQL, `DCMD_OP_ZQS: pin = `DCMD_PIN_ZQ;
                `DCMD_OP_DES: pin = `DCMD_PIN_DES;
                default: pin = `DCMD_PIN_NOP;
            endcase
            if (ee != `DCMD_ERR_NONE) pin = `DCMD_PIN_NOP;
            j = 0;
            @(negedge CLOCK);
            while (REQ_READY !== 1'b1 && j < 20) begin
                @(negedge CLOCK);
                j = j + 1;
            end
            @(posedge CLOCK);
            REQ_VALID <= 1'b0;
            @(negedge CLOCK);
            chk(REQ_DONE === 1'b1 && REQ_ERR === ee, "done or error code");
            chk(cmd === pin || op >= `DCMD_OP_PDE && op <= `DCMD_OP_LPX && cmd === 4'hF, "pins");
            if (op == `DCMD_OP_SRE || op == `DCMD_OP_PDE) cke_m = 1'b0;
            if (op == `DCMD_OP_LPX) cke_m = 1'b1;
            chk(MEM_CKE === cke_m && MEM_ODT === (s[3] && s[4]), "cke or odt");
            if (ee == `DCMD_ERR_NONE) begin
                if (op <= `DCMD_OP_RD && op != `DCMD_OP_PREA) chk(MEM_BA === b, "bank");
                if (op == `DCMD_OP_PRE || op == `DCMD_OP_PREA) chk(MEM_A[10] === op[0], "a10");
                if (op == `DCMD_OP_WR || op == `DCMD_OP_RD) chk(MEM_A[10] === ad[10] && MEM_A[12] === a12, "a10 a12");
                if (op == `DCMD_OP_ZQL || op == `DCMD_OP_ZQS) chk(MEM_A[10] === (op == `DCMD_OP_ZQL), "zq");
                if (op == `DCMD_OP_ACT || op == `DCMD_OP_MRS) chk(MEM_A === ad, "address");
                if (op == `DCMD_OP_ACT) open_m[b] = 1'b1;
                if (op == `DCMD_OP_PRE || (op == `DCMD_OP_WR || op == `DCMD_OP_RD) && ad[10]) open_m[b] = 1'b0;
                if (op == `DCMD_OP_PREA) open_m = 8'h00;
            end
            nt = 0;
            nr = 0;
            tk = 1'b0;
            for (j = 0; j < 8; j = j + 1) begin
                if (tk) chk(MEM_DQ_LO_RISE === pq[7:0] && MEM_DQ_HI_FALL === pq[31:24] && {MEM_UDM, MEM_LDM} === pmq, "lanes");
                if (tk) chk(MEM_DQ_LO_FALL === pq[23:16] && MEM_DQ_HI_RISE === pq[15:8] && MEM_DQ_OE === 1'b1 && MEM_DQS_OE === 1'b1, "lanes oe");
                if (RD_VALID === 1'b1) chk(RD_DATA === r3, "read data");
                tk = WR_TAKE === 1'b1;
                pq = pd;
                pmq = pm;
                pd = WR_DATA;
                pm = WR_MASK;
                nt = nt + tk;
                nr = nr + (RD_VALID === 1'b1);
                @(negedge CLOCK);
            end
            chk(nt == (op == `DCMD_OP_WR && ee == 0 ? (a12 ? 4 : 2) : 0), "write beats");
            chk(nr == (op == `DCMD_OP_RD && ee == 0 ? (a12 ? 4 : 2) : 0), "read beats");
            chk(BANK_OPEN === open_m && dev_open === open_m && dev_bad == 0, "bank state");
        end
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        s = $urandom(99750);
        {fail_count, comparisons, open_m, cke_m} = 0;
        cke_m = 1'b1;
        {SYS_RST, REQ_VALID, REQ_OTF, REQ_BL8, REQ_ODT, MODE_OTF_EN, MODE_RTT_EN} = 7'h40;
        {MEM_RESET_REQ, REQ_OP, REQ_BANK, REQ_ADDR, WR_DATA, WR_MASK} = 0;
        repeat (10) @(posedge CLOCK);
        @(negedge CLOCK);
        chk(MEM_CS_N === 1'b1 && MEM_CKE === 1'b0 && MEM_RESET_N === 1'b0, "reset pins");
        @(posedge CLOCK) SYS_RST <= 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            s = $urandom;
            issue(`DCMD_OP_ACT, s[2:0], s[16:3]);
            issue(`DCMD_OP_ACT, s[2:0], 14'h0000);
            issue(`DCMD_OP_WR, s[2:0], s[30:17] & 14'h3BFF);
            issue(`DCMD_OP_RD, s[2:0], 14'h0400);
            issue(`DCMD_OP_WR, s[2:0], 14'h0000);
            issue(4'hE + i[0], s[2:0], 14'h0000);
        end
        issue(`DCMD_OP_ACT, 3'h0, 14'h1234);
        issue(`DCMD_OP_ACT, 3'h5, 14'h0ABC);
        issue(`DCMD_OP_PRE, 3'h0, 14'h0000);
        issue(`DCMD_OP_PREA, 3'h0, 14'h0000);
        for (i = 0; i < 10; i = i + 1) issue(SEQ[39-4*i -: 4], i[2:0], 14'h0531);
        @(posedge CLOCK) MEM_RESET_REQ <= 1'b1;
        repeat (3) @(negedge CLOCK);
        chk(MEM_RESET_N === 1'b0 && REQ_READY === 1'b0, "reset request");
        @(posedge CLOCK) MEM_RESET_REQ <= 1'b0;
        repeat (3) @(negedge CLOCK);
        chk(MEM_RESET_N === 1'b1, "reset release");
        give_verdict;
    end
    initial begin
        #100000;
        fail_count = fail_count + 1;
        give_verdict;
    end
endmodule
